// ### design/rtc_params.svh
// Offsets, field positions, reset values and rates of the clock core.
// Assumes inclusion by bare name from the package and the core.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// ----------------------------------------
// Register locations
// ----------------------------------------
`define RTC_OFF_CTL 4'h0
`define RTC_OFF_HUND 4'h1
`define RTC_OFF_SEC 4'h2
`define RTC_OFF_MIN 4'h3
`define RTC_OFF_HOUR 4'h4
`define RTC_OFF_YD 4'h5
`define RTC_OFF_WM 4'h6
`define RTC_OFF_TMR 4'h7
`define RTC_OFF_ACR 4'h8
`define RTC_OFF_ATMR 4'hF
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTC_CTL_STOP 7
`define RTC_CTL_MODE_HI 5
`define RTC_CTL_MODE_LO 4
`define RTC_CTL_MASK 3
`define RTC_CTL_AEN 2
`define RTC_CTL_AFLAG 1
`define RTC_CTL_TFLAG 0
`define RTC_ACR_AIE 7
`define RTC_ACR_TAE 6
`define RTC_ACR_AF_HI 5
`define RTC_ACR_AF_LO 4
`define RTC_ACR_TIE 3
`define RTC_ACR_TRES_HI 2
`define RTC_HOUR_H12 7
`define RTC_HOUR_PM 6
// ----------------------------------------
// Reset values, limits, codes
// ----------------------------------------
`define RTC_RST_ZERO 8'h00
`define RTC_RST_YD 8'h01
`define RTC_RST_WM 8'h01
`define RTC_YD_DATE_MASK 8'h3F
`define RTC_WM_MONTH_MASK 8'h1F
`define RTC_HALF_SEC 8'h50
`define RTC_XTAL_HZ 16'h8000
`define RTC_TICK_HZ 16'h0064
`define RTC_TRES_STEP 3'h1
`define RTC_TRES_SEC 3'h2
`define RTC_TRES_MIN 3'h3
`define RTC_TRES_HOUR 3'h4
`define RTC_TRES_DAY 3'h5
`define RTC_AF_DAILY 2'h1
`define RTC_AF_WEEKDAY 2'h2
`define RTC_AF_EVENT 2'h2
`define RTC_AF_DATED 2'h3
`endif

// ### design/rtc_pkg.sv
// Types shared by the clock core.
// Assumes rtc_params.svh is on the include path.
`include "rtc_params.svh"
package rtc_pkg;
  // Counting source, control bits 5:4
  typedef enum logic [1:0] {
    RTC_XTAL = 2'b00,
    RTC_EVENT = 2'b01,
    RTC_MAINS = 2'b10,
    RTC_TEST = 2'b11
  } rtc_mode_type;

  typedef struct packed {
    logic [2:0] osc_sync;
    logic osc_lvl;
    logic [15:0] frac;
    logic pend;
    logic [7:0] ctl, hund, sec, mins, hour, yd, wm, tmr;
    logic [7:0][7:0] alm;
    logic [6:0][7:0] cap;
    logic [7:0] rdata;
    logic amatch, tmatch, int_act;
  } rtc_state_type;
endpackage : rtc_pkg

// ### design/rtc_core.sv
// Clock/calendar, event counter, timer and alarm core with register port.
// Assumes a bus front end that decodes locations 00-0F into strobes.
//
// Summary of operation
// - Hours register MSB selects 12-hour or 24-hour counting.
// - Mask flag strips year and weekday bits from reads of 05, 06.
// - Event mode counts six BCD digits, top to bottom, no divider.
// - Hundredths 00-99, sec/min 00-59, hours 24h or 12h AM/PM cycle.
// - Date wraps per month length; February 29 days only in year 0.
// - Month 01-12, year 0-3, weekday 0-6, timer 00-99 without carry.
// - Alarm control acts only while alarm enable bit is set.
// - Alarm registers at counter location plus 08, bitwise compare.
// - Dated ignores year/weekday, daily ignores date/month, weekday mask.
// - Enabled timer counts to 99, wraps to 0, sets timer flag.
// - Timer flag cleared only by write; drives interrupt if enabled.
// - Timer alarm sets alarm flag when timer equals alarm timer.
// - Alarm control low three bits pick timer resolution.
// - Control bits 4,5 = 1,0 select event mode on oscillator input.
// - Event alarm sets alarm flag when count equals locations 9-B.
// - Event mode timer steps per 1, 100, 10000 or 1000000 events.
// - Interrupt low while an enabled flag is set, until cleared.
// - Alarm disabled in clock mode: interrupt is a 1 Hz square wave.
// - Crystal mode divides 32.768 kHz input to a 100 Hz tick.
// - 50 Hz and event modes stop oscillator, input goes high-Z.
// - Reset gives crystal mode, 24h, Jan 1 00:00:00.00, output high.
// - Start of a read cycle snapshots all counters into latches.
`timescale 1ns/1ns
`include "rtc_params.svh"
module rtc_core
  import rtc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic rd_cycle_start,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Oscillator pins
  input wire logic osc_in_pin,
  output logic osc_in_hiz,
  output logic osc_out_pin_o,
  output logic osc_out_pin_oe,
  // Interrupt pin, open drain
  output logic int_n_o,
  output logic int_n_oe
);

  // ----------------------------------------
  // Arithmetic helpers
  // ----------------------------------------
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] top,
                                          input logic [7:0] bot);
    if (v == top) begin
      return {1'b1, bot};
    end
    if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_step

  function automatic logic [7:0] month_top(input logic [4:0] mon,
                                           input logic [1:0] yr);
    case (mon)
      5'h02: return (yr == 2'h0) ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : month_top

  // ----------------------------------------
  // State
  // ----------------------------------------
  rtc_state_type st_ff;
  rtc_state_type nxt_st;

  rtc_mode_type mode;
  logic evt, run, aen, osc_ok, osc_rise;
  logic [15:0] frac_sum;
  logic tick_x, tick_m, step;
  logic [7:0] ms_top;
  logic c_hu, c_se, c_mi, c_day;
  logic h12, hour_last;
  logic [7:0] acr;
  logic [1:0] af;
  logic ten, tsrc, tinc;
  logic t_eq, h_eq, amatch, tmatch, aset;
  logic [8:0] s_hu, s_se, s_mi, s_hr, s_dt, s_mo, s_tm;
  logic [7:0] hr_next, rd_val;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign mode = rtc_mode_type'(st_ff.ctl[`RTC_CTL_MODE_HI:`RTC_CTL_MODE_LO]);
  assign evt = (mode == RTC_EVENT);
  assign run = ~st_ff.ctl[`RTC_CTL_STOP];
  assign aen = st_ff.ctl[`RTC_CTL_AEN];
  // Alarm control is dead unless enabled
  assign acr = aen ? st_ff.alm[0] : `RTC_RST_ZERO;
  assign af = acr[`RTC_ACR_AF_HI:`RTC_ACR_AF_LO];

  // Oscillator runs in crystal and test modes
  assign osc_in_hiz = (mode == RTC_MAINS) | evt;
  assign osc_out_pin_oe = ~osc_in_hiz;
  assign osc_out_pin_o = ~st_ff.osc_lvl;

  // ----------------------------------------
  // Input filter and time base
  // ----------------------------------------
  // Level changes once stages two and three agree
  assign osc_ok = (st_ff.osc_sync[1] == st_ff.osc_sync[2]);
  assign osc_rise = osc_ok & st_ff.osc_sync[2] & ~st_ff.osc_lvl;

  // Fractional divide keeps 100 Hz exact from 32768 edges
  assign frac_sum = st_ff.frac + `RTC_TICK_HZ;
  assign tick_x = osc_rise & (mode == RTC_XTAL) & (frac_sum >= `RTC_XTAL_HZ);
  // Each mains edge is two hundredths
  assign tick_m = osc_rise & (mode == RTC_MAINS);
  assign step = run & (tick_x | tick_m | st_ff.pend | (evt & osc_rise));

  // ----------------------------------------
  // Counter chain
  // ----------------------------------------
  assign ms_top = evt ? 8'h99 : 8'h59;
  assign s_hu = bcd_step(st_ff.hund, 8'h99, 8'h00);
  assign s_se = bcd_step(st_ff.sec, ms_top, 8'h00);
  assign s_mi = bcd_step(st_ff.mins, ms_top, 8'h00);
  assign c_hu = step & s_hu[8];
  assign c_se = c_hu & s_se[8];
  assign c_mi = c_se & s_mi[8];

  assign h12 = st_ff.hour[`RTC_HOUR_H12];
  assign hour_last = h12 ? (st_ff.hour[6:0] == 7'h51) : (st_ff.hour[5:0] == 6'h23);
  assign c_day = c_mi & ~evt & hour_last;
  assign s_hr = bcd_step({2'b00, st_ff.hour[5:0]}, 8'h23, 8'h00);

  always_comb begin
    hr_next = {st_ff.hour[7:6], s_hr[5:0]};
    if (h12) begin
      if (st_ff.hour[5:0] == 6'h11) begin
        hr_next = {2'b10 | {1'b0, ~st_ff.hour[`RTC_HOUR_PM]}, 6'h12};
      end else if (st_ff.hour[5:0] == 6'h12) begin
        hr_next = {st_ff.hour[7:6], 6'h01};
      end
    end
  end

  assign s_dt = bcd_step({2'b00, st_ff.yd[5:0]},
                         month_top(st_ff.wm[4:0], st_ff.yd[7:6]), 8'h01);
  assign s_mo = bcd_step({3'b000, st_ff.wm[4:0]}, 8'h12, 8'h01);
  assign s_tm = bcd_step(st_ff.tmr, 8'h99, 8'h00);

  // ----------------------------------------
  // Timer source
  // ----------------------------------------
  assign ten = ~st_ff.ctl[`RTC_CTL_MODE_HI] & aen;
  always_comb begin
    unique case (acr[`RTC_ACR_TRES_HI:0])
      `RTC_TRES_STEP: tsrc = step;
      `RTC_TRES_SEC: tsrc = c_hu;
      `RTC_TRES_MIN: tsrc = c_se;
      `RTC_TRES_HOUR: tsrc = c_mi;
      `RTC_TRES_DAY: tsrc = c_day;
      default: tsrc = 1'b0;
    endcase
  end
  assign tinc = ten & tsrc;

  // ----------------------------------------
  // Alarm compare
  // ----------------------------------------
  assign t_eq = (st_ff.hund == st_ff.alm[1]) & (st_ff.sec == st_ff.alm[2]) &
                (st_ff.mins == st_ff.alm[3]);
  // Hour bits 7:6 must match too
  assign h_eq = t_eq & (st_ff.hour == st_ff.alm[4]);

  always_comb begin
    amatch = 1'b0;
    if (evt) begin
      amatch = (af == `RTC_AF_EVENT) & t_eq;
    end else begin
      unique case (af)
        `RTC_AF_DAILY: amatch = h_eq;
        `RTC_AF_WEEKDAY: amatch = h_eq & st_ff.alm[6][st_ff.wm[7:5]];
        `RTC_AF_DATED: amatch = h_eq & (st_ff.yd[5:0] == st_ff.alm[5][5:0]) &
                                (st_ff.wm[4:0] == st_ff.alm[6][4:0]);
        default: amatch = 1'b0;
      endcase
    end
  end
  assign tmatch = acr[`RTC_ACR_TAE] & (st_ff.tmr == st_ff.alm[7]);
  // Flag sets on entry into a match, so a clear sticks during it
  assign aset = (amatch & ~st_ff.amatch) | (tmatch & ~st_ff.tmatch);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rd_val = st_ff.ctl;
    if (reg_addr[3]) begin
      rd_val = st_ff.alm[reg_addr[2:0]];
    end else if (reg_addr != `RTC_OFF_CTL) begin
      rd_val = st_ff.cap[reg_addr[2:0] - 3'h1];
    end
    if (st_ff.ctl[`RTC_CTL_MASK]) begin
      if (reg_addr == `RTC_OFF_YD) begin
        rd_val = rd_val & `RTC_YD_DATE_MASK;
      end else if (reg_addr == `RTC_OFF_WM) begin
        rd_val = rd_val & `RTC_WM_MONTH_MASK;
      end
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.osc_sync = {st_ff.osc_sync[1:0], osc_in_pin};
    if (osc_ok) begin
      nxt_st.osc_lvl = st_ff.osc_sync[2];
    end
    if (osc_rise & (mode == RTC_XTAL)) begin
      nxt_st.frac = tick_x ? frac_sum - `RTC_XTAL_HZ : frac_sum;
    end
    nxt_st.pend = run & tick_m;

    if (step) begin
      nxt_st.hund = s_hu[7:0];
    end
    if (c_hu) begin
      nxt_st.sec = s_se[7:0];
    end
    if (c_se) begin
      nxt_st.mins = s_mi[7:0];
    end
    if (c_mi & ~evt) begin
      nxt_st.hour = hr_next;
    end
    if (c_day) begin
      nxt_st.yd[5:0] = s_dt[5:0];
      nxt_st.wm[7:5] = (st_ff.wm[7:5] == 3'h6) ? 3'h0 : st_ff.wm[7:5] + 3'h1;
      if (s_dt[8]) begin
        nxt_st.wm[4:0] = s_mo[4:0];
        if (s_mo[8]) begin
          nxt_st.yd[7:6] = st_ff.yd[7:6] + 2'h1;
        end
      end
    end
    if (tinc) begin
      nxt_st.tmr = s_tm[7:0];
    end

    nxt_st.amatch = amatch;
    nxt_st.tmatch = tmatch;
    if (rd_cycle_start) begin
      nxt_st.cap = {st_ff.tmr, st_ff.wm, st_ff.yd, st_ff.hour,
                    st_ff.mins, st_ff.sec, st_ff.hund};
    end
    if (reg_rd) begin
      nxt_st.rdata = rd_val;
    end

    // A write replaces only the addressed byte
    if (reg_wr) begin
      if (reg_addr[3]) begin
        nxt_st.alm[reg_addr[2:0]] = reg_wdata;
      end else begin
        unique case (reg_addr[2:0])
          3'h0: nxt_st.ctl = reg_wdata;
          3'h1: nxt_st.hund = reg_wdata;
          3'h2: nxt_st.sec = reg_wdata;
          3'h3: nxt_st.mins = reg_wdata;
          3'h4: nxt_st.hour = reg_wdata;
          3'h5: nxt_st.yd = reg_wdata;
          3'h6: nxt_st.wm = reg_wdata;
          3'h7: nxt_st.tmr = reg_wdata;
        endcase
      end
    end
    // Set beats a same-cycle clear
    if (aset) begin
      nxt_st.ctl[`RTC_CTL_AFLAG] = 1'b1;
    end
    if (tinc & s_tm[8]) begin
      nxt_st.ctl[`RTC_CTL_TFLAG] = 1'b1;
    end

    // Released pin reads high: square wave starts high
    if (aen) begin
      nxt_st.int_act = (acr[`RTC_ACR_AIE] & st_ff.ctl[`RTC_CTL_AFLAG]) |
                       (acr[`RTC_ACR_TIE] & st_ff.ctl[`RTC_CTL_TFLAG]);
    end else begin
      nxt_st.int_act = ~evt & (st_ff.hund >= `RTC_HALF_SEC);
    end

    if (sys_rst) begin
      nxt_st = '0;
      nxt_st.yd = `RTC_RST_YD;
      nxt_st.wm = `RTC_RST_WM;
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign reg_rdata = st_ff.rdata;
  assign int_n_o = 1'b0;
  assign int_n_oe = st_ff.int_act;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  AST_MASK_READ: assert property (
    reg_rd && reg_addr == `RTC_OFF_YD && st_ff.ctl[`RTC_CTL_MASK]
    |=> reg_rdata == ($past(st_ff.cap[4]) & `RTC_YD_DATE_MASK))
    else $error("masked year/date read wrong");
  AST_HUND_WRAP: assert property (
    step && st_ff.hund == 8'h99 && !reg_wr |=> st_ff.hund == 8'h00)
    else $error("hundredths did not wrap");
  AST_PM_TO_AM: assert property (
    c_mi && !evt && st_ff.hour == 8'hD1 && !reg_wr |=> st_ff.hour == 8'h92)
    else $error("11 PM did not roll to 12 AM");
  AST_FEB_LEAP: assert property (
    c_day && st_ff.wm[4:0] == 5'h02 && st_ff.yd == 8'h29 && !reg_wr
    |=> st_ff.yd[5:0] == 6'h01 && st_ff.wm[4:0] == 5'h03)
    else $error("leap February end wrong");
  AST_YEAR_END: assert property (
    c_day && st_ff.wm[4:0] == 5'h12 && st_ff.yd[5:0] == 6'h31 && !reg_wr
    |=> st_ff.wm[4:0] == 5'h01 && st_ff.yd[7:6] != $past(st_ff.yd[7:6]))
    else $error("year rollover wrong");
  AST_TMR_OVF: assert property (
    tinc && st_ff.tmr == 8'h99 && !reg_wr
    |=> st_ff.tmr == 8'h00 && st_ff.ctl[`RTC_CTL_TFLAG])
    else $error("timer overflow wrong");
  AST_TFLAG_STICKY: assert property (
    st_ff.ctl[`RTC_CTL_TFLAG] && !(reg_wr && reg_addr == `RTC_OFF_CTL)
    |=> st_ff.ctl[`RTC_CTL_TFLAG])
    else $error("timer flag lost");
  AST_TMR_ALARM: assert property (
    tmatch && !st_ff.tmatch |=> st_ff.ctl[`RTC_CTL_AFLAG])
    else $error("timer alarm flag not set");
  AST_INT_ALARM: assert property (
    aen && acr[`RTC_ACR_AIE] && st_ff.ctl[`RTC_CTL_AFLAG] |=> int_n_oe)
    else $error("alarm interrupt not driven");
  AST_SQUARE: assert property (
    !aen && !evt |=> int_n_oe == ($past(st_ff.hund) >= `RTC_HALF_SEC))
    else $error("1 Hz square wave wrong");
  AST_OSC_OFF: assert property (
    evt |-> !osc_out_pin_oe && osc_in_hiz)
    else $error("oscillator active in event mode");
  AST_SNAPSHOT: assert property (
    rd_cycle_start |=> st_ff.cap[0] == $past(st_ff.hund) &&
    st_ff.cap[3] == $past(st_ff.hour))
    else $error("capture latches not loaded");

  COV_DAY: cover property (c_day);
  COV_TMR_OVF: cover property (tinc && s_tm[8]);
  COV_ALARM: cover property (aset);
  COV_EVT_MILLION: cover property (evt && c_mi);

endmodule : rtc_core

// ### tb/rtc_host_model.sv
// Register-port host standing in for the two-wire bus master.
// Assumes the core samples on rising mclk; this model drives on falling mclk.
`timescale 1ns/1ns
module rtc_host_model (
  // Clock
  input wire logic mclk,
  // Register port towards the core
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic rd_cycle_start,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    rd_cycle_start = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // Released lines show the inverse, never a stale byte
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge mclk);
    rd_cycle_start = 1'b1;
    @(negedge mclk);
    rd_cycle_start = 1'b0;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge mclk);
    d = reg_rdata;
  endtask : rd
endmodule : rtc_host_model

// ### tb/tb.sv
// Self-checking bench for the clock core: counters, modes, timer, alarms.
// Assumes rtc_host_model drives the register port; the bench drives the pin.
`timescale 1ns/1ns
`include "rtc_params.svh"
module tb;
  logic mclk;
  logic sys_rst;
  logic osc_in_pin;
  logic [3:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic rd_cycle_start;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic osc_in_hiz;
  logic osc_out_pin_o;
  logic osc_out_pin_oe;
  logic int_n_o;
  logic int_n_oe;
  int mismatches;
  int cmp_count;

  rtc_core dut_u (.mclk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .rd_cycle_start,
    .reg_rd, .reg_rdata, .osc_in_pin, .osc_in_hiz, .osc_out_pin_o, .osc_out_pin_oe,
    .int_n_o, .int_n_oe);
  rtc_host_model host_u (.mclk, .reg_addr, .reg_wr, .reg_wdata, .rd_cycle_start,
    .reg_rd, .reg_rdata);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check1

  task automatic expect_reg(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    check8(d, exp);
  endtask : expect_reg

  // Levels held 6 cycles, twice the synchroniser need
  task automatic pulse();
    @(negedge mclk);
    osc_in_pin = 1'b1;
    repeat (6) @(negedge mclk);
    osc_in_pin = 1'b0;
    repeat (6) @(negedge mclk);
  endtask : pulse

  task automatic clear_flags();
    host_u.wr(`RTC_OFF_CTL, 8'h14);
    repeat (2) @(negedge mclk);
  endtask : clear_flags

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_reset();
    expect_reg(`RTC_OFF_CTL, 8'h00);
    expect_reg(`RTC_OFF_HOUR, 8'h00);
    expect_reg(`RTC_OFF_YD, 8'h01);
    expect_reg(`RTC_OFF_WM, 8'h01);
    check1(int_n_oe, 1'b0);
    check1(osc_in_hiz, 1'b0);
    check1(osc_out_pin_oe, 1'b1);
    check1(osc_out_pin_o, 1'b1);
    check1(int_n_o, 1'b0);
  endtask : sc_reset

  // 327 edges leave the fraction just short of one tick
  task automatic sc_crystal();
    host_u.wr(`RTC_OFF_HUND, 8'h49);
    repeat (327) pulse();
    expect_reg(`RTC_OFF_HUND, 8'h49);
    check1(int_n_oe, 1'b0);
    pulse();
    expect_reg(`RTC_OFF_HUND, 8'h50);
    check1(int_n_oe, 1'b1);
  endtask : sc_crystal

  task automatic sc_cascade();
    logic [7:0] t [4][6];
    t = '{'{8'h23, 8'h68, 8'hC2, 8'h00, 8'h41, 8'h03},
          '{8'hD1, 8'h29, 8'h02, 8'h92, 8'h01, 8'h23},
          '{8'h23, 8'h30, 8'h04, 8'h00, 8'h01, 8'h25},
          '{8'h23, 8'hF1, 8'hD2, 8'h00, 8'h01, 8'h01}};
    host_u.wr(`RTC_OFF_CTL, 8'h20);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(`RTC_OFF_HUND, 8'h98);
      host_u.wr(`RTC_OFF_SEC, 8'h59);
      host_u.wr(`RTC_OFF_MIN, 8'h59);
      host_u.wr(`RTC_OFF_HOUR, t[i][0]);
      host_u.wr(`RTC_OFF_YD, t[i][1]);
      host_u.wr(`RTC_OFF_WM, t[i][2]);
      pulse();
      expect_reg(`RTC_OFF_HUND, 8'h00);
      expect_reg(`RTC_OFF_SEC, 8'h00);
      expect_reg(`RTC_OFF_MIN, 8'h00);
      expect_reg(`RTC_OFF_HOUR, t[i][3]);
      expect_reg(`RTC_OFF_YD, t[i][4]);
      expect_reg(`RTC_OFF_WM, t[i][5]);
    end
    check1(osc_in_hiz, 1'b1);
    check1(osc_out_pin_oe, 1'b0);
  endtask : sc_cascade

  task automatic sc_mask();
    host_u.wr(`RTC_OFF_CTL, 8'h28);
    host_u.wr(`RTC_OFF_YD, 8'hC5);
    host_u.wr(`RTC_OFF_WM, 8'hE3);
    expect_reg(`RTC_OFF_YD, 8'h05);
    expect_reg(`RTC_OFF_WM, 8'h03);
    host_u.wr(`RTC_OFF_CTL, 8'h20);
    expect_reg(`RTC_OFF_YD, 8'hC5);
  endtask : sc_mask

  task automatic sc_timer();
    host_u.wr(`RTC_OFF_CTL, 8'h14);
    host_u.wr(`RTC_OFF_ACR, 8'h09);
    host_u.wr(`RTC_OFF_TMR, 8'h99);
    host_u.wr(4'h1, 8'h99);
    host_u.wr(4'h2, 8'h99);
    host_u.wr(4'h3, 8'h00);
    pulse();
    expect_reg(4'h1, 8'h00);
    expect_reg(4'h3, 8'h01);
    expect_reg(`RTC_OFF_TMR, 8'h00);
    expect_reg(`RTC_OFF_CTL, 8'h15);
    check1(int_n_oe, 1'b1);
    check1(osc_in_hiz, 1'b1);
    pulse();
    expect_reg(`RTC_OFF_TMR, 8'h01);
    expect_reg(`RTC_OFF_CTL, 8'h15);
    host_u.wr(`RTC_OFF_ACR, 8'h08);
    pulse();
    expect_reg(`RTC_OFF_TMR, 8'h01);
    clear_flags();
    check1(int_n_oe, 1'b0);
  endtask : sc_timer

  task automatic sc_event_alarm();
    host_u.wr(4'h1, 8'h41);
    host_u.wr(4'h2, 8'h00);
    host_u.wr(4'h3, 8'h00);
    host_u.wr(4'h9, 8'h42);
    host_u.wr(4'hA, 8'h00);
    host_u.wr(4'hB, 8'h00);
    host_u.wr(`RTC_OFF_ACR, 8'hA0);
    expect_reg(`RTC_OFF_CTL, 8'h14);
    pulse();
    expect_reg(`RTC_OFF_CTL, 8'h16);
    check1(int_n_oe, 1'b1);
    clear_flags();
    check1(int_n_oe, 1'b0);
  endtask : sc_event_alarm

  task automatic sc_timer_alarm();
    host_u.wr(`RTC_OFF_ACR, 8'hC1);
    host_u.wr(`RTC_OFF_ATMR, 8'h05);
    host_u.wr(`RTC_OFF_TMR, 8'h04);
    pulse();
    expect_reg(`RTC_OFF_TMR, 8'h05);
    expect_reg(`RTC_OFF_CTL, 8'h16);
    check1(int_n_oe, 1'b1);
    clear_flags();
    check1(int_n_oe, 1'b0);
  endtask : sc_timer_alarm

  // Daily then dated alarm in 50 Hz mode, 12-hour format
  task automatic sc_clock_alarm();
    host_u.wr(`RTC_OFF_ACR, 8'h90);
    host_u.wr(4'h9, 8'h00);
    host_u.wr(4'hA, 8'h11);
    host_u.wr(4'hB, 8'h20);
    // Alarm hour copies the counter's format and PM bits
    host_u.wr(4'hC, 8'h85);
    host_u.wr(`RTC_OFF_HUND, 8'h98);
    host_u.wr(`RTC_OFF_SEC, 8'h10);
    host_u.wr(`RTC_OFF_MIN, 8'h20);
    host_u.wr(`RTC_OFF_HOUR, 8'h85);
    host_u.wr(`RTC_OFF_CTL, 8'h24);
    expect_reg(`RTC_OFF_CTL, 8'h24);
    pulse();
    expect_reg(`RTC_OFF_CTL, 8'h26);
    check1(int_n_oe, 1'b1);
    host_u.wr(`RTC_OFF_CTL, 8'h24);
    repeat (2) @(negedge mclk);
    check1(int_n_oe, 1'b0);
    // Year and weekday bits of the alarm differ from the counters
    host_u.wr(`RTC_OFF_ACR, 8'hB0);
    host_u.wr(4'hD, 8'h05);
    host_u.wr(4'hE, 8'h03);
    expect_reg(`RTC_OFF_CTL, 8'h26);
    check1(int_n_oe, 1'b1);
  endtask : sc_clock_alarm

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    mismatches = 0;
    cmp_count = 0;
    osc_in_pin = 1'b0;
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    sc_reset();
    sc_crystal();
    sc_cascade();
    sc_mask();
    sc_timer();
    sc_event_alarm();
    sc_timer_alarm();
    sc_clock_alarm();
    conclude();
  end

  initial begin
    #900000;
    mismatches++;
    conclude();
  end
endmodule : tb
